// [pkg/cpp_pkg.sv]
// Purpose: constants for the card presence probe threshold block
// Assumes: 8-bit registers, one per aligned 32-bit word
// Notes: byte address is four times the register index
package cpp_pkg;
  // ----------------------------------------------------------------------
  // register indices and byte address shift
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_OPTIONS = 8'h3a;
  localparam logic [7:0] IDX_Q_LOWER = 8'h3f;
  localparam logic [7:0] IDX_Q_UPPER = 8'h40;
  localparam logic [7:0] IDX_I_LOWER = 8'h41;
  localparam logic [7:0] IDX_I_RESULT = 8'h42;
  localparam logic [7:0] IDX_Q_RESULT = 8'h43;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h50;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h51;
  localparam logic [7:0] IDX_CONTROL = 8'h52;
  localparam logic [9:0] ADDR_SHIFT_W = 10'h002;
  // ----------------------------------------------------------------------
  // fields
  // ----------------------------------------------------------------------
  localparam int LIMIT_W = 6;
  localparam int HI_BIT = 7;
  localparam int LO_BIT = 6;
  localparam int MUTE_BIT = 6;
  localparam int OPT_FULL_DRIVE = 3;
  localparam int OPT_FILTER = 2;
  localparam int OPT_Q_DRIFT = 1;
  localparam int OPT_I_DRIFT = 0;
  localparam int IRQ_PROBE = 0;
  localparam int CTL_START = 0;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [5:0] LIMIT_RESET = 6'h00;
  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 8000;
  localparam int FILTER_TIME_PS = 4720000;
  localparam int FILTER_TIME_NS_X100 = 472;
  localparam int FILTER_CYCLES = (FILTER_TIME_PS / CLK_PERIOD_PS) < 1 ?
    1 : FILTER_TIME_PS / CLK_PERIOD_PS;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_DECIDE} cpp_state_t;
endpackage

// [logic/cpp_top.sv]
// Purpose: card presence probe limits, results, decision and interrupt
// Assumes: AHB-Lite slave, one clock, measurements synchronous to SYS_CLK
// Notes: status register clears on read; filter averages first and last
//
// How it works
// RULE1 - q_upper_limit bits 7:6 give i_upper_limit bits 3:2.
// RULE2 - i_lower_limit bits 7:6 give i_upper_limit bits 1:0.
// RULE3 - q_lower_limit bits 7:6 give i_upper_limit bits 5:4.
// RULE4 - interrupt when I measurement exceeds i_upper_limit.
// RULE5 - q_upper_limit in 40h bits 5:0; Q above it interrupts.
// RULE6 - i_lower_limit in 41h bits 5:0; I below it interrupts.
// RULE7 - probe interrupt sets probe_irq_flag in irq_status_0.
// RULE8 - 42h shows latest I measurement, top bits zero.
// RULE9 - 43h shows latest Q measurement, bit 7 zero.
// RULE10 - detect_irq_mute blocks probe interrupts until next probe.
// RULE11 - options register exists only on later revision, bits 7:4 zero.
// RULE12 - full_drive_during_detect selects full transmitter supply.
// RULE13 - filter uses averaged values, sampling bounded to 4.72us.
// RULE14 - q_drift_flag reports Q change during filtered probe.
// RULE15 - i_drift_flag reports I change during filtered probe.
// RULE16 - results update together, compare once; new probe re-arms.
`timescale 1ns/1ps
module cpp_top #(
  parameter bit LATE_REVISION = 1'b1
) (
  // clock, reset, enable
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic CLK_EN,
  // ahb-lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // measurement chain
  input wire logic [5:0] I_MEAS,
  input wire logic [5:0] Q_MEAS,
  input wire logic MEAS_VALID,
  output logic PROBE_ACTIVE,
  output logic TX_FULL_DRIVE,
  // interrupt
  output logic IRQ
);
  logic [7:0] q_lower_limit_reg;
  logic [7:0] q_upper_limit_reg;
  logic [7:0] i_lower_limit_reg;
  logic [5:0] i_res;
  logic [5:0] q_res;
  logic mute;
  logic full_drive;
  logic filter_en;
  logic q_drift;
  logic i_drift;
  logic irq_status;
  logic irq_mask;
  logic wr_pend;
  logic [7:0] wr_idx;
  logic rd_status;
  logic start_req;
  logic [5:0] i_upper;
  logic [5:0] i_first;
  logic [5:0] q_first;
  logic [5:0] i_cur;
  logic [5:0] q_cur;
  logic [9:0] samp_cnt;
  logic probe_evt;
  logic [7:0] rd_idx;
  logic [7:0] next_rdata;
  cpp_pkg::cpp_state_t state;
  logic have_first;
  logic i_moved;
  logic q_moved;
  logic next_irq_status;

  function automatic logic [7:0] word_idx(input logic [31:0] a);
    word_idx = a[9:2];
  endfunction

  function automatic logic [5:0] avg6(input logic [5:0] a,
                                      input logic [5:0] b);
    logic [6:0] s;
    s = {1'b0, a} + {1'b0, b};
    avg6 = s[6:1];
  endfunction

  // a pending write to one register index, used by several decoders
  function automatic logic wr_to(input logic pend, input logic [7:0] widx,
                                 input logic [7:0] target);
    wr_to = pend && (widx == target);
  endfunction

  // ----------------------------------------------------------------------
  // bus slave: zero wait states
  // ----------------------------------------------------------------------
  logic access;
  assign access = HSEL && HREADY && (HTRANS == cpp_pkg::HTRANS_NONSEQ);
  assign rd_idx = word_idx(HADDR);
  assign start_req = wr_to(wr_pend, wr_idx, cpp_pkg::IDX_CONTROL) &&
    HWDATA[cpp_pkg::CTL_START];

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      wr_pend <= 1'b0;
      wr_idx <= cpp_pkg::REG_RESET;
      rd_status <= 1'b0;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else if (CLK_EN) begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      wr_pend <= access && HWRITE;
      wr_idx <= rd_idx;
      rd_status <= access && !HWRITE &&
        (rd_idx == cpp_pkg::IDX_IRQ_STATUS);
    end
  end

  // unmapped addresses read zero and ignore writes
  always_comb begin
    next_rdata = cpp_pkg::REG_RESET;
    case (rd_idx)
      cpp_pkg::IDX_OPTIONS: begin
        if (LATE_REVISION) begin // RULE11
          next_rdata = {4'h0, full_drive, filter_en, q_drift, i_drift};
        end
      end
      cpp_pkg::IDX_Q_LOWER: next_rdata = q_lower_limit_reg;
      cpp_pkg::IDX_Q_UPPER: next_rdata = q_upper_limit_reg;
      cpp_pkg::IDX_I_LOWER: next_rdata = i_lower_limit_reg;
      cpp_pkg::IDX_I_RESULT: next_rdata = {2'h0, i_res}; // RULE8
      cpp_pkg::IDX_Q_RESULT: next_rdata = {1'b0, mute, q_res}; // RULE9
      cpp_pkg::IDX_IRQ_STATUS: next_rdata = {7'h00, irq_status};
      cpp_pkg::IDX_IRQ_MASK: next_rdata = {7'h00, irq_mask};
      cpp_pkg::IDX_CONTROL: next_rdata = {7'h00, state != cpp_pkg::ST_IDLE};
      default: next_rdata = cpp_pkg::REG_RESET;
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      HRDATA <= 32'h0000_0000;
    end else if (CLK_EN) begin
      if (access && !HWRITE) begin
        HRDATA <= {24'h00_0000, next_rdata};
      end
    end
  end

  // ----------------------------------------------------------------------
  // limit registers
  // ----------------------------------------------------------------------
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      q_lower_limit_reg <= cpp_pkg::REG_RESET;
      q_upper_limit_reg <= cpp_pkg::REG_RESET;
      i_lower_limit_reg <= cpp_pkg::REG_RESET;
      irq_mask <= 1'b0;
    end else if (CLK_EN && wr_pend) begin
      case (wr_idx)
        cpp_pkg::IDX_Q_LOWER: q_lower_limit_reg <= HWDATA[7:0];
        cpp_pkg::IDX_Q_UPPER: q_upper_limit_reg <= HWDATA[7:0];
        cpp_pkg::IDX_I_LOWER: i_lower_limit_reg <= HWDATA[7:0];
        cpp_pkg::IDX_IRQ_MASK: irq_mask <= HWDATA[cpp_pkg::IRQ_PROBE];
        default: ;
      endcase
    end
  end

  assign i_upper = {q_lower_limit_reg[cpp_pkg::HI_BIT:cpp_pkg::LO_BIT], // RULE3
                    q_upper_limit_reg[cpp_pkg::HI_BIT:cpp_pkg::LO_BIT], // RULE1
                    i_lower_limit_reg[cpp_pkg::HI_BIT:cpp_pkg::LO_BIT]}; // RULE2

  // ----------------------------------------------------------------------
  // options
  // ----------------------------------------------------------------------
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      full_drive <= 1'b0;
      filter_en <= 1'b0;
    end else if (CLK_EN && wr_pend && LATE_REVISION &&
                 wr_idx == cpp_pkg::IDX_OPTIONS) begin // RULE11
      full_drive <= HWDATA[cpp_pkg::OPT_FULL_DRIVE];
      filter_en <= HWDATA[cpp_pkg::OPT_FILTER];
    end
  end

  // ----------------------------------------------------------------------
  // probe sequencer
  // ----------------------------------------------------------------------
  // filtered mode stays in sampling until the sampling bound, however early the second sample comes
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      state <= cpp_pkg::ST_IDLE;
      i_first <= cpp_pkg::LIMIT_RESET;
      q_first <= cpp_pkg::LIMIT_RESET;
      i_cur <= cpp_pkg::LIMIT_RESET;
      q_cur <= cpp_pkg::LIMIT_RESET;
      PROBE_ACTIVE <= 1'b0;
      TX_FULL_DRIVE <= 1'b0;
    end else if (CLK_EN) begin
      case (state)
        cpp_pkg::ST_IDLE: begin
          if (start_req) begin
            state <= cpp_pkg::ST_SAMPLE;
            PROBE_ACTIVE <= 1'b1;
            TX_FULL_DRIVE <= full_drive; // RULE12
          end
        end
        cpp_pkg::ST_SAMPLE: begin
          if (MEAS_VALID) begin
            i_cur <= I_MEAS;
            q_cur <= Q_MEAS;
            if (!(filter_en && LATE_REVISION) || !have_first) begin
              i_first <= I_MEAS;
              q_first <= Q_MEAS;
            end
          end
          if (MEAS_VALID && !(filter_en && LATE_REVISION)) begin
            state <= cpp_pkg::ST_DECIDE;
          end else if (samp_cnt >=
                       10'(cpp_pkg::FILTER_CYCLES - 1)) begin // RULE13
            state <= cpp_pkg::ST_DECIDE;
          end
        end
        cpp_pkg::ST_DECIDE: begin
          state <= cpp_pkg::ST_IDLE;
          PROBE_ACTIVE <= 1'b0;
          TX_FULL_DRIVE <= 1'b0;
        end
        default: state <= cpp_pkg::ST_IDLE;
      endcase
    end
  end

  // sample window counter; it restarts outside sampling so a long
  // filtered window never leaks into the next probe
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      samp_cnt <= 10'h000;
    end else if (CLK_EN) begin
      if (state == cpp_pkg::ST_SAMPLE) begin
        samp_cnt <= samp_cnt + 10'h001;
      end else begin
        samp_cnt <= 10'h000;
      end
    end
  end

  // the first valid sample of a probe opens the filter average, however
  // late in the window it arrives
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      have_first <= 1'b0;
    end else if (CLK_EN) begin
      if (state == cpp_pkg::ST_IDLE) begin
        have_first <= 1'b0;
      end else if (state == cpp_pkg::ST_SAMPLE && MEAS_VALID) begin
        have_first <= 1'b1;
      end
    end
  end

  // drift is any step between successive samples, not only first against
  // last, so a value that wanders and returns is still reported
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      i_moved <= 1'b0;
      q_moved <= 1'b0;
    end else if (CLK_EN) begin
      if (state == cpp_pkg::ST_IDLE) begin
        i_moved <= 1'b0;
        q_moved <= 1'b0;
      end else if (state == cpp_pkg::ST_SAMPLE && MEAS_VALID &&
                   have_first) begin
        if (I_MEAS != i_cur) begin
          i_moved <= 1'b1; // RULE15
        end
        if (Q_MEAS != q_cur) begin
          q_moved <= 1'b1; // RULE14
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // results, drift flags and decision
  // ----------------------------------------------------------------------
  logic [5:0] i_eval;
  logic [5:0] q_eval;
  assign i_eval = filter_en ? avg6(i_first, i_cur) : i_cur; // RULE13
  assign q_eval = filter_en ? avg6(q_first, q_cur) : q_cur;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      i_res <= cpp_pkg::LIMIT_RESET;
      q_res <= cpp_pkg::LIMIT_RESET;
      i_drift <= 1'b0;
      q_drift <= 1'b0;
      probe_evt <= 1'b0;
    end else if (CLK_EN) begin
      probe_evt <= 1'b0;
      if (state == cpp_pkg::ST_DECIDE) begin
        i_res <= i_eval; // RULE16
        q_res <= q_eval; // RULE16
        i_drift <= filter_en && i_moved; // RULE15
        q_drift <= filter_en && q_moved; // RULE14
        probe_evt <= (i_eval > i_upper) || // RULE4
          (q_eval > q_upper_limit_reg[cpp_pkg::LIMIT_W-1:0]) || // RULE5
          (i_eval < i_lower_limit_reg[cpp_pkg::LIMIT_W-1:0]); // RULE6
      end
    end
  end

  // mute set by software, cleared when a new probe starts
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      mute <= 1'b0;
    end else if (CLK_EN) begin
      if (state == cpp_pkg::ST_IDLE && start_req) begin
        mute <= 1'b0; // RULE16
      end else if (wr_to(wr_pend, wr_idx, cpp_pkg::IDX_Q_RESULT)) begin
        mute <= HWDATA[cpp_pkg::MUTE_BIT]; // RULE10
      end
    end
  end

  // ----------------------------------------------------------------------
  // interrupt status: set beats read-clear
  // ----------------------------------------------------------------------
  // IRQ follows the status it is about to hold, so it adds no lag behind
  // the flag; a mask write still takes one cycle to show
  always_comb begin
    next_irq_status = irq_status;
    if (probe_evt && !mute) begin // RULE10
      next_irq_status = 1'b1; // RULE7
    end else if (rd_status ||
                 (wr_to(wr_pend, wr_idx, cpp_pkg::IDX_Q_RESULT) &&
                  HWDATA[cpp_pkg::MUTE_BIT])) begin // RULE10
      next_irq_status = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      irq_status <= 1'b0;
      IRQ <= 1'b0;
    end else if (CLK_EN) begin
      irq_status <= next_irq_status;
      IRQ <= next_irq_status && irq_mask;
    end
  end
endmodule

// [sim/cpp_meas_model.sv]
// Purpose: model of the analogue I/Q measurement chain
// Assumes: two sample pulses per probe, dly+1 and dly+2 cycles after start
// Notes: lines carry the inverse value outside the sample cycle
`timescale 1ns/1ps
module cpp_meas_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // settings from the bench
  input wire logic [5:0] i_val,
  input wire logic [5:0] q_val,
  input wire logic [5:0] i_alt,
  input wire logic [5:0] q_alt,
  input wire logic [7:0] dly,
  // measurement chain
  input wire logic active,
  output logic [5:0] i_meas,
  output logic [5:0] q_meas,
  output logic meas_valid
);
  logic [7:0] cnt;
  logic hit;
  logic hit2;
  assign hit = active && cnt == dly;
  assign hit2 = active && cnt == dly + 8'h01;
  // counter parks at ff so a probe gets no more than two samples while dly is below fe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 8'h00;
      meas_valid <= 1'b0;
      i_meas <= 6'h00;
      q_meas <= 6'h00;
    end else begin
      cnt <= !active ? 8'h00 : (cnt == 8'hff ? cnt : cnt + 8'h01);
      meas_valid <= hit || hit2;
      i_meas <= hit ? i_val : (hit2 ? i_alt : ~i_val);
      q_meas <= hit ? q_val : (hit2 ? q_alt : ~q_val);
    end
  end
endmodule

// [sim/cpp_monitor.sv]
// Purpose: port checker for cpp_top
// Assumes: one clock, asynchronous active high reset
// Notes: bound to cpp_top at the foot of this file
`timescale 1ns/1ps
module cpp_monitor (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // bus
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  // probe
  input wire logic PROBE_ACTIVE,
  input wire logic TX_FULL_DRIVE,
  input wire logic IRQ
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  logic rd;
  logic wr;
  logic [7:0] idx;
  assign idx = HADDR[9:2];
  assign rd = HSEL && HREADY && HTRANS == 2'h2 && !HWRITE;
  assign wr = HSEL && HREADY && HTRANS == 2'h2 && HWRITE;
  bus_okay_a: assert property (HREADYOUT && !HRESP)
    else $error("bus not ready or error");
  rdata_top_a: assert property (HRDATA[31:8] == 24'h0)
    else $error("read data upper bits set");
  probe_start_a: assert property (wr && idx == cpp_pkg::IDX_CONTROL
    ##1 HWDATA[0] |-> ##[1:2] PROBE_ACTIVE) else $error("probe not started");
  tx_idle_a: assert property (!PROBE_ACTIVE &&
    !$past(PROBE_ACTIVE) |-> !TX_FULL_DRIVE) else $error("drive outside probe");
  tx_hold_a: assert property (PROBE_ACTIVE &&
    $past(PROBE_ACTIVE) |-> $stable(TX_FULL_DRIVE)) else $error("drive moved");
  probe_bound_a: assert property ($rose(PROBE_ACTIVE)
    |-> ##[1:600] !PROBE_ACTIVE) else $error("probe too long");
  irq_quiet_a: assert property ($rose(IRQ) |-> !PROBE_ACTIVE)
    else $error("interrupt during probe");
  opt_rsvd_a: assert property (rd && idx == 8'h3a
    |=> HRDATA[7:4] == 4'h0) else $error("options reserved bits set");
  ires_rsvd_a: assert property (rd && idx == 8'h42
    |=> HRDATA[7:6] == 2'h0) else $error("i result reserved bits set");
  qres_rsvd_a: assert property (rd && idx == 8'h43
    |=> !HRDATA[7]) else $error("q result reserved bit set");
  cover property ($rose(IRQ));
  cover property ($rose(PROBE_ACTIVE) && TX_FULL_DRIVE);
  cover property (rd && idx == 8'h42);
endmodule
bind cpp_top cpp_monitor u_mon (.SYS_CLK, .RST, .HSEL, .HADDR, .HTRANS,
  .HWRITE, .HWDATA, .HREADY, .HRDATA, .HREADYOUT, .HRESP, .PROBE_ACTIVE,
  .TX_FULL_DRIVE, .IRQ);

// [sim/tb.sv]
// Purpose: register level test of the card presence probe block
// Assumes: zero wait slave, byte address is four times the index
// Notes: limits chosen so a wrong upper limit bit order shows
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rdv;
  logic hready, hreadyout, hresp, mv, pa, txf, irq, txe, e;
  logic [5:0] im, qm;
  logic [5:0] mi = 6'h00;
  logic [5:0] mq = 6'h00;
  logic [5:0] mi2 = 6'h00;
  logic [5:0] mq2 = 6'h00;
  logic ce = 1'b1;
  logic [7:0] dly = 8'h00;
  logic [5:0] ti [5] = '{6'h34, 6'h35, 6'h10, 6'h07, 6'h08};
  logic [5:0] tq [5] = '{6'h20, 6'h10, 6'h21, 6'h10, 6'h20};
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  assign hready = hreadyout;
  cpp_top uut (.SYS_CLK(clk), .RST(rst), .CLK_EN(ce), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .I_MEAS(im), .Q_MEAS(qm),
    .MEAS_VALID(mv), .PROBE_ACTIVE(pa), .TX_FULL_DRIVE(txf), .IRQ(irq));
  cpp_meas_model u_chain (.clk(clk), .rst(rst), .i_val(mi), .q_val(mq),
    .i_alt(mi2), .q_alt(mq2), .dly(dly), .active(pa), .i_meas(im),
    .q_meas(qm), .meas_valid(mv));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // address phase held until hready, then data phase until hready
  task automatic bus(input logic w, input logic [7:0] idx,
      input logic [7:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= cpp_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'b00};
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, rdv);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 8'h00, rdv);
    chk(rdv, exp);
  endtask
  task automatic go(input logic [5:0] i, input logic [5:0] q,
      input logic [7:0] d);
    mi <= i;
    mq <= q;
    mi2 <= i;
    mq2 <= q;
    dly <= d;
    wr(cpp_pkg::IDX_CONTROL, 8'h01);
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (pa !== 1'b1 && n < 5) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, txf}, {31'h0, txe});
    while (pa !== 1'b0 && n < 700) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, pa}, 32'h0);
    repeat (3) @(posedge clk);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      give_verdict();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rdc(8'h60, 32'h0);
    wr(8'h3a, 8'hff);
    bus(1'b0, 8'h3a, 8'h00, rdv);
    chk(rdv & 32'hfffffffc, 32'h0c);
    wr(8'h3a, 8'h08);
    wr(8'h3f, 8'hc0);
    wr(8'h40, 8'h60);
    wr(8'h41, 8'h08);
    rdc(8'h3f, 32'hc0);
    rdc(8'h40, 32'h60);
    rdc(8'h41, 32'h08);
    // a write while the clock enable is low must leave no trace
    ce <= 1'b0;
    wr(8'h3f, 8'h00);
    ce <= 1'b1;
    rdc(8'h3f, 32'hc0);
    wr(cpp_pkg::IDX_IRQ_MASK, 8'h01);
    txe = 1'b1;
    for (int k = 0; k < 5; k++) begin
      if (k == 4) begin
        wr(8'h3a, 8'h00);
        txe = 1'b0;
      end
      e = ti[k] > 6'h34 || tq[k] > 6'h20 || ti[k] < 6'h08;
      go(ti[k], tq[k], 8'h02);
      wait_done();
      chk({31'h0, irq}, {31'h0, e});
      rdc(8'h42, {26'h0, ti[k]});
      rdc(8'h43, {26'h0, tq[k]});
      rdc(cpp_pkg::IDX_IRQ_STATUS, {31'h0, e});
      rdc(cpp_pkg::IDX_IRQ_STATUS, 32'h0);
    end
    wr(cpp_pkg::IDX_IRQ_MASK, 8'h00);
    go(6'h35, 6'h10, 8'h02);
    wait_done();
    chk({31'h0, irq}, 32'h0);
    rdc(cpp_pkg::IDX_IRQ_STATUS, 32'h1);
    wr(cpp_pkg::IDX_IRQ_MASK, 8'h01);
    go(6'h35, 6'h10, 8'h28);
    wr(8'h43, 8'h40);
    wait_done();
    rdc(cpp_pkg::IDX_IRQ_STATUS, 32'h0);
    rdc(8'h43, 32'h50);
    go(6'h35, 6'h10, 8'h02);
    wait_done();
    rdc(cpp_pkg::IDX_IRQ_STATUS, 32'h1);
    // filtered probes: two samples averaged, a step between them is drift
    wr(8'h3a, 8'h04);
    go(6'h10, 6'h20, 8'h02);
    mi2 <= 6'h12;
    wait_done();
    rdc(8'h3a, 32'h05);
    rdc(8'h42, 32'h11);
    rdc(8'h43, 32'h20);
    rdc(cpp_pkg::IDX_IRQ_STATUS, 32'h0);
    go(6'h10, 6'h20, 8'h02);
    mq2 <= 6'h22;
    wait_done();
    chk({31'h0, irq}, 32'h1);
    rdc(8'h3a, 32'h06);
    rdc(8'h43, 32'h21);
    rdc(cpp_pkg::IDX_IRQ_STATUS, 32'h1);
    give_verdict();
  end
endmodule
